/* File: shared/sfp_pkg.sv */
package sfp_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_THRESHOLD_STATUS   = 32'h5000_1214;
  localparam logic [31:0] ADDR_FIFO_STATUS        = 32'h5000_1218;
  localparam logic [31:0] ADDR_RX_FIFO_READ_PORT  = 32'h5000_121c;
  localparam logic [31:0] ADDR_TX_FIFO_WRITE_PORT = 32'h5000_1220;
  localparam logic [31:0] ADDR_CHIP_SELECT_CONFIG = 32'h5000_1224;
  localparam logic [31:0] ADDR_FIFO_HIGH_HALF     = 32'h5000_1228;
  localparam logic [31:0] ADDR_TX_BUFFER_LOW      = 32'h5000_122c;
  localparam logic [31:0] ADDR_TX_BUFFER_HIGH     = 32'h5000_1230;

  // Threshold status fields
  localparam int BIT_TX_THRESHOLD = 0;
  localparam int BIT_RX_THRESHOLD = 1;

  // FIFO status fields
  localparam int BIT_TXN_ACTIVE   = 15;
  localparam int BIT_RX_OVERFLOW  = 14;
  localparam int BIT_TX_FULL      = 13;
  localparam int BIT_RX_EMPTY     = 12;
  localparam int POS_TX_LEVEL     = 6;
  localparam int POS_RX_LEVEL     = 0;
  localparam int LEVEL_W          = 6;

  // Chip-select codes
  localparam logic [2:0] CS_NONE  = 3'h0;
  localparam logic [2:0] CS_PIN_A = 3'h1;
  localparam logic [2:0] CS_PIN_B = 3'h2;
  localparam logic [2:0] CS_GPIO  = 3'h4;

  // Reset values
  localparam logic [15:0] RST_HIGH_HALF = 16'h0000;
  localparam logic [2:0]  RST_CS_SEL    = 3'h0;
  localparam logic [31:0] RST_PRDATA    = 32'h0000_0000;

  // Data path
  localparam int DATA_W     = 32;
  localparam int HALF_W     = 16;
  localparam int FIFO_DEPTH = 16;
  // Word length field value above which the high half is used
  localparam logic [4:0] LEN_FIELD_SPLIT = 5'h0f;

endpackage : sfp_pkg

/* File: src/sfp_top.sv */
`timescale 1ns/1ns
// Overview of operation
// - Receive threshold flag is high while receive level exceeds threshold.
// - Transmit threshold flag is high while transmit level is at or below threshold.
// - Master mode reports whether a serial transaction is in progress.
// - Word arriving into a full receive FIFO is dropped and sets overflow.
// - Status reports transmit FIFO completely full.
// - Status reports receive FIFO empty; resets to one.
// - Status shows transmit level in bits 11:6, receive level in 5:0.
// - Read port returns low 16 bits of the oldest received word.
// - Write port pushes a low word into transmit FIFO; reads give zero.
// - Chip-select field picks pin A, pin B, GPIO or none in master mode.
// - Shared high-half register carries upper 16 bits; written before low.
// - Direct low port loads the shift buffer bypassing FIFO, slave only.
// - Direct high port holds upper bytes for the slave-mode direct load; writable in any mode.
// - Four-bit thresholds are compared against FIFO occupancies.
// - FIFO reset holds both FIFOs empty and clears overflow.
// - Word length is field plus one; decides use of the high half.
// - Mode bit selects master or slave and gates mode-specific features.

module sfp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       clr,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } sfp_fifo_s;

  sfp_fifo_s r;
  sfp_fifo_s next_r;
  logic      push;
  logic      pop;

  assign in_ready  = !clr && (r.cnt != CNT_FULL);
  assign out_valid = !clr && (r.cnt != '0);
  assign out_data  = r.mem[r.rd];
  assign level     = r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap naturally, so DEPTH must be a power of two
  always_comb begin
    next_r = r;
    if (clr) begin
      next_r.wr  = '0;
      next_r.rd  = '0;
      next_r.cnt = '0;
    end else begin
      if (push) begin
        next_r.mem[r.wr] = in_data;
        next_r.wr        = r.wr + 1'b1;
      end
      if (pop) begin
        next_r.rd = r.rd + 1'b1;
      end
      if (push && !pop) begin
        next_r.cnt = r.cnt + 1'b1;
      end else if (pop && !push) begin
        next_r.cnt = r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : sfp_fifo

module sfp_top
  import sfp_pkg::*;
(
  // Clocks and reset
  input  wire logic        core_clk,
  input  wire logic        spi_clk,
  input  wire logic        rst_n,
  // Register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller configuration
  input  wire logic [3:0]  rx_threshold,
  input  wire logic [3:0]  tx_threshold,
  input  wire logic        cfg_fifo_reset,
  input  wire logic [4:0]  cfg_word_length,
  input  wire logic        cfg_slave_mode,
  // Serial link
  input  wire logic        sdi,
  output logic             sdo,
  input  wire logic        slave_sel_n,
  output logic             select_pin_a_n,
  output logic             select_pin_b_n,
  output logic             select_gpio_n,
  // Status to controller
  output logic             rx_overflow_flag
);
  localparam int LVW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic              tx_req;
    logic [DATA_W-1:0] tx_word;
    logic              ack_s1;
    logic              ack_s2;
    logic              rxt_s1;
    logic              rxt_s2;
    logic              rxt_seen;
    logic              bsy_s1;
    logic              bsy_s2;
    logic [HALF_W-1:0] high_half;
    logic [HALF_W-1:0] force_high;
    logic [2:0]        cs_sel;
    logic              ovf;
    logic [31:0]       prdata;
  } sfp_core_s;

  typedef struct packed {
    logic              req_s1;
    logic              req_s2;
    logic              req_seen;
    logic              slv_s1;
    logic              slv_s2;
    logic              sel_s1;
    logic              sel_s2;
    logic [4:0]        len_s1;
    logic [4:0]        len_s2;
    logic              busy;
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] cap;
    logic [4:0]        cnt;
    logic              out_bit;
    logic              rx_tgl;
    logic [DATA_W-1:0] rx_word;
  } sfp_link_s;

  sfp_core_s r;
  sfp_core_s next_r;
  sfp_link_s l;
  sfp_link_s next_l;

  logic              rd_setup;
  logic              wr_access;
  logic              addr_ok;
  logic              wide;
  logic              tx_pend;
  logic              force_go;
  logic              rx_evt;
  logic              txn_active;
  logic              tx_in_valid;
  logic              tx_in_ready;
  logic              tx_out_valid;
  logic              tx_out_ready;
  logic [DATA_W-1:0] tx_out_data;
  logic [LVW-1:0]    tx_level;
  logic              rx_in_ready;
  logic              rx_out_valid;
  logic              rx_out_ready;
  logic [DATA_W-1:0] rx_out_data;
  logic [LVW-1:0]    rx_level;
  logic [DATA_W-1:0] rx_push_data;
  logic [DATA_W-1:0] tx_push_data;
  logic              rx_th_flag;
  logic              tx_th_flag;
  logic [15:0]       fifo_status;

  assign addr_ok = (paddr == ADDR_THRESHOLD_STATUS)
                || (paddr == ADDR_FIFO_STATUS)
                || (paddr == ADDR_RX_FIFO_READ_PORT)
                || (paddr == ADDR_TX_FIFO_WRITE_PORT)
                || (paddr == ADDR_CHIP_SELECT_CONFIG)
                || (paddr == ADDR_FIFO_HIGH_HALF)
                || (paddr == ADDR_TX_BUFFER_LOW)
                || (paddr == ADDR_TX_BUFFER_HIGH);
  // Read data is captured in the setup phase so that prdata is a flop
  assign rd_setup  = psel && !penable && !pwrite;
  assign wr_access = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;
  assign prdata    = r.prdata;

  assign wide = cfg_word_length > LEN_FIELD_SPLIT;

  assign rx_th_flag = rx_level > LVW'(rx_threshold);
  assign tx_th_flag = tx_level <= LVW'(tx_threshold);

  assign tx_pend = r.tx_req ^ r.ack_s2;
  assign rx_evt  = r.rxt_s2 ^ r.rxt_seen;

  assign txn_active = !cfg_slave_mode && (r.bsy_s2 || tx_pend);

  assign fifo_status = {txn_active, r.ovf, !tx_in_ready, !rx_out_valid,
                        LEVEL_W'(tx_level), LEVEL_W'(rx_level)};

  // Direct load in slave mode bypasses the FIFO
  assign force_go = wr_access && (paddr == ADDR_TX_BUFFER_LOW)
                 && cfg_slave_mode && !tx_pend;

  // Write port push, with high half when wide
  assign tx_in_valid  = wr_access && (paddr == ADDR_TX_FIFO_WRITE_PORT);
  assign tx_push_data = wide ? {r.high_half, pwdata[15:0]}
                             : {16'h0000, pwdata[15:0]};
  // Back-pressure: the FIFO stalls while a word waits at the crossing
  assign tx_out_ready = !tx_pend && !force_go;

  // Pop one word per read of a non-empty read port
  assign rx_out_ready = rd_setup && (paddr == ADDR_RX_FIFO_READ_PORT);
  assign rx_push_data = l.rx_word;

  // FIFO reset holds both FIFOs empty
  sfp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .clr       (cfg_fifo_reset),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (tx_push_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .out_data  (tx_out_data),
    .level     (tx_level)
  );

  sfp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .clr       (cfg_fifo_reset),
    .in_valid  (rx_evt),
    .in_ready  (rx_in_ready),
    .in_data   (rx_push_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_out_data),
    .level     (rx_level)
  );

  always_comb begin
    next_r        = r;
    next_r.ack_s1 = l.req_seen;
    next_r.ack_s2 = r.ack_s1;
    next_r.rxt_s1 = l.rx_tgl;
    next_r.rxt_s2 = r.rxt_s1;
    next_r.rxt_seen = r.rxt_s2;
    next_r.bsy_s1 = l.busy;
    next_r.bsy_s2 = r.bsy_s1;
    if (force_go) begin
      next_r.tx_word = {r.force_high, pwdata[15:0]};
      next_r.tx_req  = !r.tx_req;
    end else if (tx_out_valid && tx_out_ready) begin
      next_r.tx_word = tx_out_data;
      next_r.tx_req  = !r.tx_req;
    end
    // Overflow; a word dropped under FIFO reset is no overflow
    if (rx_evt && !rx_in_ready && !cfg_fifo_reset) begin
      next_r.ovf = 1'b1;
    end else if (cfg_fifo_reset) begin
      next_r.ovf = 1'b0;
    end
    if (wr_access) begin
      unique case (paddr)
        ADDR_CHIP_SELECT_CONFIG: next_r.cs_sel     = pwdata[2:0];
        // Shared high half written before the low half
        ADDR_FIFO_HIGH_HALF:     next_r.high_half  = pwdata[15:0];
        // Upper bytes for the next direct load
        ADDR_TX_BUFFER_HIGH:     next_r.force_high = pwdata[15:0];
        default: ;
      endcase
    end
    if (rd_setup) begin
      next_r.prdata = RST_PRDATA;
      unique case (paddr)
        ADDR_THRESHOLD_STATUS: begin
          next_r.prdata[BIT_RX_THRESHOLD] = rx_th_flag;
          next_r.prdata[BIT_TX_THRESHOLD] = tx_th_flag;
        end
        ADDR_FIFO_STATUS:        next_r.prdata[15:0] = fifo_status;
        ADDR_RX_FIFO_READ_PORT: begin
          // Oldest word, low half; empty reads give zero
          if (rx_out_valid) begin
            next_r.prdata[15:0] = rx_out_data[15:0];
            if (wide) begin
              next_r.high_half = rx_out_data[31:16];
            end
          end
        end
        ADDR_CHIP_SELECT_CONFIG: next_r.prdata[2:0]  = r.cs_sel;
        ADDR_FIFO_HIGH_HALF:     next_r.prdata[15:0] = r.high_half;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign select_pin_a_n   = !(!cfg_slave_mode && (r.cs_sel == CS_PIN_A));
  assign select_pin_b_n   = !(!cfg_slave_mode && (r.cs_sel == CS_PIN_B));
  assign select_gpio_n    = !(!cfg_slave_mode && (r.cs_sel == CS_GPIO));
  assign rx_overflow_flag = r.ovf;

  // Link domain: MSB first, capture on the rising link edge.
  // Mode and length cross as quasi-static levels; change them only idle.
  assign sdo = l.out_bit;

  always_comb begin
    next_l        = l;
    next_l.req_s1 = r.tx_req;
    next_l.req_s2 = l.req_s1;
    next_l.slv_s1 = cfg_slave_mode;
    next_l.slv_s2 = l.slv_s1;
    next_l.sel_s1 = !slave_sel_n;
    next_l.sel_s2 = l.sel_s1;
    next_l.len_s1 = cfg_word_length;
    next_l.len_s2 = l.len_s1;
    if (!l.busy) begin
      if (l.slv_s2 ? l.sel_s2 : (l.req_s2 != l.req_seen)) begin
        next_l.busy  = 1'b1;
        next_l.cnt   = '0;
        next_l.cap   = '0;
        next_l.shift = (l.req_s2 != l.req_seen) ? r.tx_word : '0;
        next_l.out_bit  = next_l.shift[l.len_s2];
        next_l.req_seen = l.req_s2;
      end
    end else if (l.slv_s2 && !l.sel_s2) begin
      // Select dropped mid-word: the partial word is discarded
      next_l.busy = 1'b0;
    end else begin
      next_l.cap     = {l.cap[DATA_W-2:0], sdi};
      next_l.shift   = {l.shift[DATA_W-2:0], 1'b0};
      next_l.out_bit = next_l.shift[l.len_s2];
      next_l.cnt     = l.cnt + 1'b1;
      if (l.cnt == l.len_s2) begin
        next_l.busy    = 1'b0;
        next_l.rx_word = next_l.cap;
        next_l.rx_tgl  = !l.rx_tgl;
      end
    end
  end

  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_ovf_set:     assert property (rx_evt && !rx_in_ready && !cfg_fifo_reset
                   |=> rx_overflow_flag)
    else $error("overflow not set on push into full FIFO");
  a_ovf_sticky:  assert property (r.ovf && !cfg_fifo_reset |=> r.ovf)
    else $error("overflow cleared without FIFO reset");
  a_ovf_clear:   assert property (cfg_fifo_reset && !rx_evt |=> !r.ovf)
    else $error("FIFO reset did not clear overflow");
  a_thresh_read: assert property (rd_setup && paddr == ADDR_THRESHOLD_STATUS
                   |=> prdata[1:0] == {$past(rx_level) > $past(rx_threshold),
                       $past(tx_level) <= $past(tx_threshold)})
    else $error("threshold flags read back wrong");
  a_status_read: assert property (rd_setup && paddr == ADDR_FIFO_STATUS
                   |=> prdata[13:12] == {$past(tx_level) == FIFO_DEPTH,
                       $past(rx_level) == 0})
    else $error("full or empty flag read back wrong");
  a_pop_level:   assert property (rd_setup && paddr == ADDR_RX_FIFO_READ_PORT
                   && rx_level != 0 && !rx_evt && !cfg_fifo_reset
                   |=> rx_level == $past(rx_level) - 1)
    else $error("receive level not decremented by read");
  a_push_level:  assert property (tx_in_valid && tx_in_ready
                   && !(tx_out_valid && tx_out_ready)
                   |=> tx_level == $past(tx_level) + 1)
    else $error("transmit level not incremented by write");
  a_wport_zero:  assert property (rd_setup && paddr == ADDR_TX_FIFO_WRITE_PORT
                   |=> prdata == 0)
    else $error("write port read not zero");
  a_cs_decode:   assert property (!cfg_slave_mode && r.cs_sel == CS_PIN_B
                   |-> !select_pin_b_n && select_pin_a_n && select_gpio_n)
    else $error("chip select decode wrong");
  a_slave_idle:  assert property (cfg_slave_mode |-> !fifo_status[15])
    else $error("transaction flag set in slave mode");
  a_empty_read:  assert property (rd_setup && paddr == ADDR_RX_FIFO_READ_PORT
                   && rx_level == 0 |=> prdata == 0)
    else $error("empty read returned data");

  c_overflow:   cover property (rx_evt && !rx_in_ready && !cfg_fifo_reset);
  c_tx_full:    cover property (tx_level == FIFO_DEPTH);
  c_wide_pop:   cover property (rx_out_ready && rx_out_valid && wide);
  c_force_load: cover property (force_go);
endmodule : sfp_top

/* File: tb/sfp_spi_peer.sv */
`timescale 1ns/1ns
module sfp_spi_peer (
  // Link
  input  wire logic        spi_clk,
  input  wire logic        rst_n,
  input  wire logic        sel_n,
  input  wire logic        sdo,
  output logic             sdi,
  // Bench control and observation
  input  wire logic        reply_bit,
  output logic [63:0]      seen
);
  // Works on the falling edge so both lines are settled at the rising edge
  always @(negedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= 64'h0;
      sdi  <= 1'b0;
    end else if (!sel_n) begin
      seen <= {seen[62:0], sdo};
      sdi  <= reply_bit;
    end else begin
      // Not selected: the line carries no stale data
      sdi <= ~sdi;
    end
  end
endmodule : sfp_spi_peer

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench
  import sfp_pkg::*;
;
  logic        core_clk, spi_clk, rst_n, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [3:0]  rx_threshold, tx_threshold;
  logic        cfg_fifo_reset, cfg_slave_mode, slave_sel_n, reply_bit;
  logic [4:0]  cfg_word_length;
  logic        sdi, sdo, select_pin_a_n, select_pin_b_n, select_gpio_n;
  logic        rx_overflow_flag;
  logic [63:0] seen;
  logic [15:0] lo, hi;
  logic [2:0]  cs_codes [4];
  integer      seed, errors, tests_run, i, n;

  always #2 core_clk = ~core_clk;
  initial begin
    spi_clk = 1'b0;
    #13;
    forever #40 spi_clk = ~spi_clk;
  end

  sfp_top sfp_top_inst (
    .core_clk(core_clk), .spi_clk(spi_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_threshold(rx_threshold), .tx_threshold(tx_threshold),
    .cfg_fifo_reset(cfg_fifo_reset), .cfg_word_length(cfg_word_length),
    .cfg_slave_mode(cfg_slave_mode), .sdi(sdi), .sdo(sdo),
    .slave_sel_n(slave_sel_n), .select_pin_a_n(select_pin_a_n),
    .select_pin_b_n(select_pin_b_n), .select_gpio_n(select_gpio_n),
    .rx_overflow_flag(rx_overflow_flag));

  sfp_spi_peer sfp_spi_peer_inst (
    .spi_clk(spi_clk), .rst_n(rst_n), .sel_n(select_pin_a_n), .sdo(sdo),
    .sdi(sdi), .reply_bit(reply_bit), .seen(seen));

  task summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task check(input string what, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task apb_rd(input logic [31:0] a);
    @(posedge core_clk);
    #1 psel = 1'b1;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = a;
    @(posedge core_clk);
    #1 penable = 1'b1;
    #1 err = pslverr;
    @(posedge core_clk);
    #1 rd = prdata;
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb_rd

  task apb_wr(input logic [31:0] a, d);
    @(posedge core_clk);
    #1 psel = 1'b1;
    penable = 1'b0;
    pwrite = 1'b1;
    paddr = a;
    pwdata = d;
    @(posedge core_clk);
    #1 penable = 1'b1;
    @(posedge core_clk);
    #1 psel = 1'b0;
    penable = 1'b0;
  endtask : apb_wr

  function logic [1:0] exp_thr(input int rxl, txl);
    return {rxl >= int'(rx_threshold) + 1, txl <= int'(tx_threshold)};
  endfunction : exp_thr

  task stat_chk(input int rxl, txl);
    apb_rd(ADDR_THRESHOLD_STATUS);
    check("thr_flags", rd[1:0], exp_thr(rxl, txl));
    apb_rd(ADDR_FIFO_STATUS);
    check("levels", rd[13:0],
          {txl == 16, rxl == 0, 6'(txl), 6'(rxl)});
  endtask : stat_chk

  task fifo_clr;
    @(posedge core_clk);
    #1 cfg_fifo_reset = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 cfg_fifo_reset = 1'b0;
  endtask : fifo_clr

  // Link needs sync time after the last word, so settle before looking
  task wait_idle;
    for (n = 0; n < 3000; n++) begin
      apb_rd(ADDR_FIFO_STATUS);
      if (rd[15] === 1'b0 && rd[11:6] === 6'h0) break;
    end
    repeat (150) @(posedge core_clk);
  endtask : wait_idle

  task peer_chk(input logic [31:0] w);
    logic hit;
    hit = 1'b0;
    for (i = 0; i <= 16; i++)
      if (seen[i +: 32] === w) hit = 1'b1;
    check("sdo_word", hit, 1);
  endtask : peer_chk

  initial begin
    #300000;
    errors++;
    summarize;
  end

  initial begin
    core_clk = 1'b0;
    seed = 32'h40d8;
    errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rx_threshold = 4'($random(seed));
    tx_threshold = 4'($random(seed));
    cfg_fifo_reset = 1'b0;
    cfg_word_length = 5'h1f;
    cfg_slave_mode = 1'b0;
    slave_sel_n = 1'b1;
    reply_bit = 1'b1;
    cs_codes = '{CS_NONE, CS_PIN_A, CS_PIN_B, CS_GPIO};
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    stat_chk(0, 0);
    apb_rd(ADDR_RX_FIFO_READ_PORT);
    check("empty_rd", rd, 0);
    apb_rd(ADDR_FIFO_HIGH_HALF);
    check("high_rst", rd, 0);
    apb_rd(ADDR_TX_FIFO_WRITE_PORT);
    check("wr_port_rd", rd, 0);
    apb_rd(32'h5000_1234);
    check("unmapped_err", err, 1);
    check("unmapped_rd", rd, 0);
    check("ovf_rst", rx_overflow_flag, 0);
    for (i = 0; i < 4; i++) begin
      apb_wr(ADDR_CHIP_SELECT_CONFIG, 32'(cs_codes[i]));
      apb_rd(ADDR_CHIP_SELECT_CONFIG);
      check("cs_rd", rd[2:0], cs_codes[i]);
      check("cs_pins", {select_pin_a_n, select_pin_b_n, select_gpio_n},
            {cs_codes[i] != CS_PIN_A, cs_codes[i] != CS_PIN_B,
             cs_codes[i] != CS_GPIO});
    end
    @(posedge core_clk);
    #1 cfg_slave_mode = 1'b1;
    #2 check("slave_pins", {select_pin_a_n, select_pin_b_n,
                            select_gpio_n}, 3'h7);
    // Slave with no select: only one word leaves for the crossing, extra writes must be dropped
    for (i = 0; i < 20; i++)
      apb_wr(ADDR_TX_FIFO_WRITE_PORT, $random(seed));
    stat_chk(0, 16);
    fifo_clr;
    stat_chk(0, 0);
    @(posedge core_clk);
    #1 cfg_slave_mode = 1'b0;
    // The word staged in slave mode goes out now; drop what it brought back
    wait_idle;
    fifo_clr;
    apb_wr(ADDR_CHIP_SELECT_CONFIG, 32'(CS_PIN_A));
    hi = 16'($random(seed));
    lo = 16'($random(seed));
    apb_wr(ADDR_FIFO_HIGH_HALF, 32'(hi));
    apb_wr(ADDR_TX_FIFO_WRITE_PORT, 32'(lo));
    apb_rd(ADDR_FIFO_STATUS);
    check("active", rd[15], 1);
    wait_idle;
    check("idle", rd[15], 0);
    peer_chk({hi, lo});
    stat_chk(1, 0);
    apb_rd(ADDR_RX_FIFO_READ_PORT);
    check("rx_low", rd[15:0], 16'hffff);
    apb_rd(ADDR_FIFO_HIGH_HALF);
    check("rx_high", rd[15:0], 16'hffff);
    stat_chk(0, 0);
    cfg_word_length = 5'h03;
    for (i = 0; i < 17; i++) begin
      for (n = 0; n < 200; n++) begin
        apb_rd(ADDR_FIFO_STATUS);
        if (rd[13] === 1'b0) break;
      end
      apb_wr(ADDR_TX_FIFO_WRITE_PORT, $random(seed));
    end
    wait_idle;
    stat_chk(16, 0);
    check("ovf_bit", rd[14], 1);
    check("ovf_port", rx_overflow_flag, 1);
    for (i = 16; i > 0; i--) begin
      apb_rd(ADDR_RX_FIFO_READ_PORT);
      check("rx_narrow", rd[15:0], 16'h000f);
      stat_chk(i - 1, 0);
    end
    check("ovf_hold", rx_overflow_flag, 1);
    fifo_clr;
    #2 check("ovf_clear", rx_overflow_flag, 0);
    summarize;
  end
endmodule : testbench
